// file: src/packet_buffer_cfg.svh
// Register offsets, field positions, reset values and codes of the packet buffer link side
`ifndef PACKET_BUFFER_CFG_SVH
`define PACKET_BUFFER_CFG_SVH
`define PB_ADDR_W 24
`define PB_CTRL_OFFSET 24'h000000
`define PB_STATUS_OFFSET 24'h000004
`define PB_DROPS_OFFSET 24'h000008
`define PB_CTRL_RESET 2'h0
`define PB_CTRL_CRF_EN 0
`define PB_CTRL_TXFC 1
`define PB_STATUS_TXOCC_LSB 0
`define PB_STATUS_RXFREE_LSB 8
`define PB_STATUS_PARTNER_LSB 16
`define PB_STATUS_LONG 24
`define PB_STATUS_MASTER 25
`define PB_USER_DISC 0
`define PB_USER_CRF 1
`define PB_USER_SOP 3
`define PB_USER_RESP 4
`define PB_KEEP_ALL 8'hff
`define PB_STAT_CAP 6'h1e
`define PB_ID_MASK_SHORT 6'h1f
`define PB_ID_MASK_LONG 6'h3f
`define PB_ACK_NONE 6'h3f
`define PB_RESP_OKAY 2'h0
`define PB_RESP_SLVERR 2'h2
`endif

// file: src/packet_buffer_pkg.sv
// Types shared by the packet buffer link side
package packet_buffer_pkg;
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] keep;
    logic last;
    logic [7:0] user;
  } beat_type;
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_type;
endpackage

// file: src/packet_buffer_phy_link_side.sv
// Packet buffer: transmit slots by ackID, receive beat buffer, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "packet_buffer_cfg.svh"
// Notes on behaviour
// - First outgoing beat carries flow flag in bit1
// - Last beat bit0 set means discard packet
// - Receive bit0 on last beat drops packet
// - Qualifier bit i covers data byte i
// - Requests go out only while permitted
// - Long symbol mode makes ackIDs six bits
// - Rewind restarts sending at next packet index
// - Acknowledged ackID frees one or more slots
// - Status output never all ones or 5'h1f
// - Status estimates free packets, capped at 30
// - Flow mode output follows transmitter-controlled mode
module packet_buffer_phy_link_side #(
  parameter int TX_SLOTS = 8,
  parameter int TX_BEATS = 4,
  parameter int RX_DEPTH = 32,
  parameter int RX_PKT_BEATS = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic txInValid,
  output var logic txInReady,
  input wire packet_buffer_pkg::beat_type txInBeat,
  output var logic rxOutValid,
  input wire logic rxOutReady,
  output var packet_buffer_pkg::beat_type rxOutBeat,
  output var logic phytValid,
  input wire logic phytReady,
  output var packet_buffer_pkg::beat_type phytBeat,
  input wire logic phyrValid,
  output var logic phyrReady,
  input wire packet_buffer_pkg::beat_type phyrBeat,
  input wire logic masterEnable,
  input wire logic longSymbolMode,
  input wire logic rewindRequest,
  input wire logic [5:0] nextPacketIndex,
  input wire logic [5:0] lastAckId,
  input wire logic [5:0] partnerBufStat,
  output var logic [5:0] bufStat,
  output var logic txFlowControl,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [23:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output var logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  input wire logic [23:0] s_axi_araddr,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp
);
  localparam int SW = $clog2(TX_SLOTS);
  localparam int BW = $clog2(TX_BEATS);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int PSH = $clog2(RX_PKT_BEATS);

  function automatic logic [1:0] regSel(input logic [23:0] a);
    if (a == `PB_CTRL_OFFSET) regSel = 2'h0;
    else if (a == `PB_STATUS_OFFSET) regSel = 2'h1;
    else if (a == `PB_DROPS_OFFSET) regSel = 2'h2;
    else regSel = 2'h3;
  endfunction

  // Slots are indexed by the low ackID bits, so TX_SLOTS must divide 32
  packet_buffer_pkg::beat_type txMem [TX_SLOTS*TX_BEATS];
  packet_buffer_pkg::beat_type rxMem [RX_DEPTH];
  packet_buffer_pkg::tx_state_type txState_q, txState_d;
  packet_buffer_pkg::beat_type phyt_q, phyt_d, rxOut_q, rxOut_d, txRead, rxStore;
  logic phytValid_q, phytValid_d, rxOutValid_q, rxOutValid_d;
  logic txInReady_q, txInReady_d, phyrReady_q, phyrReady_d;
  logic [5:0] wrId_q, wrId_d, sendId_q, sendId_d, tailId_q, tailId_d, ackPrev_q, ackPrev_d;
  logic [BW-1:0] wrBeat_q, wrBeat_d, sendBeat_q, sendBeat_d;
  logic rewindPend_q, rewindPend_d, outFirst_q, outFirst_d;
  logic [PW:0] rxWr_q, rxWr_d, rxCommit_q, rxCommit_d, rxRd_q, rxRd_d, rxUsed;
  logic rxFirst_q, rxFirst_d;
  logic [5:0] bufStat_q, bufStat_d, idMask, txOcc, ackNext;
  logic [31:0] freePkts;
  logic txFlowControl_q, txFlowControl_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [15:0] drops_q, drops_d;
  logic txAccept, phytLoad, txStart, txStartResp, rxAccept, rxDrop, rxLoad;
  logic [SW+BW-1:0] txRdIdx;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
  logic [23:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
  logic wStrb0_q, wStrb0_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  assign idMask = longSymbolMode ? `PB_ID_MASK_LONG : `PB_ID_MASK_SHORT;
  assign txAccept = txInValid & txInReady_q;
  assign rxAccept = phyrValid & phyrReady_q;
  assign phytLoad = !phytValid_q || phytReady;
  assign rxLoad = !rxOutValid_q || rxOutReady;
  assign ackNext = (lastAckId + 6'h01) & idMask;

  // Transmit path: store by ackID, send complete packets, free on acknowledge
  always_comb begin
    wrId_d = wrId_q;
    wrBeat_d = wrBeat_q;
    sendId_d = sendId_q;
    sendBeat_d = sendBeat_q;
    tailId_d = tailId_q;
    ackPrev_d = ackPrev_q;
    txState_d = txState_q;
    phyt_d = phyt_q;
    phytValid_d = phytValid_q && !phytReady;
    rewindPend_d = rewindPend_q | rewindRequest;
    outFirst_d = outFirst_q;
    txStart = 1'b0;
    txRdIdx = {sendId_q[SW-1:0], sendBeat_q};
    if (txState_q == packet_buffer_pkg::TX_IDLE) begin
      txRdIdx = {sendId_q[SW-1:0], {BW{1'b0}}};
    end
    txRead = txMem[txRdIdx];
    txStartResp = txRead.user[`PB_USER_RESP];
    if (txAccept) begin
      if (txInBeat.last) begin
        wrId_d = (wrId_q + 6'h01) & idMask;
        wrBeat_d = '0;
      end else if (wrBeat_q != BW'(TX_BEATS - 1)) begin
        wrBeat_d = wrBeat_q + BW'(1);
      end
    end
    if ((lastAckId & idMask) != (ackPrev_q & idMask)) begin
      tailId_d = ackNext;
      ackPrev_d = lastAckId;
    end
    case (txState_q)
      packet_buffer_pkg::TX_IDLE: begin
        if (rewindPend_q) begin
          sendId_d = nextPacketIndex & idMask;
          rewindPend_d = rewindRequest;
        end else if (phytLoad && sendId_q != wrId_q && (masterEnable || txStartResp)) begin
          txStart = 1'b1;
          phyt_d = txRead;
          phyt_d.user = '0;
          phyt_d.user[`PB_USER_CRF] = txRead.user[`PB_USER_CRF] & ctrl_q[`PB_CTRL_CRF_EN];
          phytValid_d = 1'b1;
          if (txRead.last) begin
            sendId_d = (sendId_q + 6'h01) & idMask;
          end else begin
            sendBeat_d = BW'(1);
            txState_d = packet_buffer_pkg::TX_SEND;
          end
        end
      end
      packet_buffer_pkg::TX_SEND: begin
        if (phytLoad) begin
          phytValid_d = 1'b1;
          phyt_d = txRead;
          phyt_d.user = '0;
          if (rewindPend_q) begin
            // Cut the packet short so the link drops it, then restart
            phyt_d.last = 1'b1;
            phyt_d.keep = `PB_KEEP_ALL;
            phyt_d.user[`PB_USER_DISC] = 1'b1;
            sendId_d = nextPacketIndex & idMask;
            rewindPend_d = rewindRequest;
            txState_d = packet_buffer_pkg::TX_IDLE;
          end else if (txRead.last || sendBeat_q == BW'(TX_BEATS - 1)) begin
            phyt_d.last = 1'b1;
            sendId_d = (sendId_q + 6'h01) & idMask;
            txState_d = packet_buffer_pkg::TX_IDLE;
          end else begin
            sendBeat_d = sendBeat_q + BW'(1);
          end
        end
      end
      default: txState_d = packet_buffer_pkg::TX_IDLE;
    endcase
    if (phytValid_q && phytReady) begin
      outFirst_d = phyt_q.last;
    end
    txOcc = (wrId_d - tailId_d) & idMask;
    txInReady_d = txOcc < 6'(TX_SLOTS);
  end

  always_ff @(posedge clk_sys) begin
    if (txAccept) begin
      txMem[{wrId_q[SW-1:0], wrBeat_q}] <= txInBeat;
    end
    if (rxAccept) begin
      rxMem[rxWr_q[PW-1:0]] <= rxStore;
    end
  end

  // Receive path: beats kept uncommitted until a clean last beat arrives
  always_comb begin
    rxWr_d = rxWr_q;
    rxCommit_d = rxCommit_q;
    rxRd_d = rxRd_q;
    rxFirst_d = rxFirst_q;
    rxOut_d = rxOut_q;
    rxOutValid_d = rxOutValid_q && !rxOutReady;
    drops_d = drops_q;
    rxDrop = 1'b0;
    // Reserved bits are cleared; flow flag kept on first beat only, when enabled
    rxStore = phyrBeat;
    rxStore.user = '0;
    rxStore.user[`PB_USER_CRF] = phyrBeat.user[`PB_USER_CRF] & rxFirst_q
        & ctrl_q[`PB_CTRL_CRF_EN];
    if (rxAccept) begin
      rxFirst_d = phyrBeat.last;
      if (phyrBeat.last && phyrBeat.user[`PB_USER_DISC]) begin
        rxDrop = 1'b1;
        rxWr_d = rxCommit_q;
        drops_d = drops_q + 16'h0001;
      end else begin
        rxWr_d = rxWr_q + (PW+1)'(1);
        if (phyrBeat.last) begin
          rxCommit_d = rxWr_q + (PW+1)'(1);
        end
      end
    end
    if (rxLoad && rxRd_q != rxCommit_q) begin
      rxOut_d = rxMem[rxRd_q[PW-1:0]];
      rxOutValid_d = 1'b1;
      rxRd_d = rxRd_q + (PW+1)'(1);
    end
    rxUsed = rxWr_d - rxRd_d;
    phyrReady_d = rxUsed < (PW+1)'(RX_DEPTH);
    freePkts = 32'((PW+1)'((PW+1)'(RX_DEPTH) - rxUsed) >> PSH);
    bufStat_d = (freePkts > 32'(`PB_STAT_CAP)) ? `PB_STAT_CAP : freePkts[5:0];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txState_q <= packet_buffer_pkg::TX_IDLE;
      phyt_q <= '0;
      phytValid_q <= 1'b0;
      txInReady_q <= 1'b0;
      wrId_q <= 6'h00;
      wrBeat_q <= '0;
      sendId_q <= 6'h00;
      sendBeat_q <= '0;
      tailId_q <= 6'h00;
      ackPrev_q <= `PB_ACK_NONE;
      rewindPend_q <= 1'b0;
      outFirst_q <= 1'b1;
      rxWr_q <= '0;
      rxCommit_q <= '0;
      rxRd_q <= '0;
      rxFirst_q <= 1'b1;
      rxOut_q <= '0;
      rxOutValid_q <= 1'b0;
      phyrReady_q <= 1'b0;
      drops_q <= 16'h0000;
      bufStat_q <= 6'h00;
    end else begin
      txState_q <= txState_d;
      phyt_q <= phyt_d;
      phytValid_q <= phytValid_d;
      txInReady_q <= txInReady_d;
      wrId_q <= wrId_d;
      wrBeat_q <= wrBeat_d;
      sendId_q <= sendId_d;
      sendBeat_q <= sendBeat_d;
      tailId_q <= tailId_d;
      ackPrev_q <= ackPrev_d;
      rewindPend_q <= rewindPend_d;
      outFirst_q <= outFirst_d;
      rxWr_q <= rxWr_d;
      rxCommit_q <= rxCommit_d;
      rxRd_q <= rxRd_d;
      rxFirst_q <= rxFirst_d;
      rxOut_q <= rxOut_d;
      rxOutValid_q <= rxOutValid_d;
      phyrReady_q <= phyrReady_d;
      drops_q <= drops_d;
      bufStat_q <= bufStat_d;
    end
  end

  // Register slave: one write and one read in flight, answer one cycle after both halves held
  always_comb begin
    awHeld_d = awHeld_q | (s_axi_awvalid & awready_q);
    wHeld_d = wHeld_q | (s_axi_wvalid & wready_q);
    awAddr_d = (s_axi_awvalid & awready_q) ? s_axi_awaddr : awAddr_q;
    wData_d = (s_axi_wvalid & wready_q) ? s_axi_wdata : wData_q;
    wStrb0_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb[0] : wStrb0_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    if (awHeld_q && wHeld_q && !bvalid_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (regSel(awAddr_q) == 2'h3) ? `PB_RESP_SLVERR : `PB_RESP_OKAY;
      if (regSel(awAddr_q) == 2'h0 && wStrb0_q) begin
        ctrl_d = wData_q[1:0];
      end
    end
    awready_d = !awHeld_d;
    wready_d = !wHeld_d;
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h00000000;
      rresp_d = `PB_RESP_OKAY;
      case (regSel(s_axi_araddr))
        2'h0: rdata_d[1:0] = ctrl_q;
        2'h1: begin
          rdata_d[`PB_STATUS_TXOCC_LSB +: 6] = (wrId_q - tailId_q) & idMask;
          rdata_d[`PB_STATUS_RXFREE_LSB +: 6] = bufStat_q;
          rdata_d[`PB_STATUS_PARTNER_LSB +: 6] = partnerBufStat;
          rdata_d[`PB_STATUS_LONG] = longSymbolMode;
          rdata_d[`PB_STATUS_MASTER] = masterEnable;
        end
        2'h2: rdata_d[15:0] = drops_q;
        default: rresp_d = `PB_RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
    txFlowControl_d = ctrl_q[`PB_CTRL_TXFC];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 24'h000000;
      wData_q <= 32'h00000000;
      wStrb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      ctrl_q <= `PB_CTRL_RESET;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
      txFlowControl_q <= 1'b0;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb0_q <= wStrb0_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      txFlowControl_q <= txFlowControl_d;
    end
  end

  assign txInReady = txInReady_q;
  assign rxOutValid = rxOutValid_q;
  assign rxOutBeat = rxOut_q;
  assign phytValid = phytValid_q;
  assign phytBeat = phyt_q;
  assign phyrReady = phyrReady_q;
  assign bufStat = bufStat_q;
  assign txFlowControl = txFlowControl_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_crf_first_beat: assert property (phytValid_q && phyt_q.user[`PB_USER_CRF] |-> outFirst_q && ctrl_q[`PB_CTRL_CRF_EN]) else $error("flow flag off first beat");
  chk_disc_on_last: assert property (phytValid_q && phyt_q.user[`PB_USER_DISC] |-> phyt_q.last) else $error("discontinue without last");
  chk_rx_drop_rewind: assert property (rxDrop |=> rxWr_q == $past(rxCommit_q) && $stable(rxCommit_q)) else $error("dropped packet kept");
  chk_request_gate: assert property (txStart && !txStartResp |-> masterEnable) else $error("request sent while gated");
  chk_ack_width: assert property (!longSymbolMode && !$past(longSymbolMode) |-> !wrId_q[5] && !sendId_q[5] && !tailId_q[5]) else $error("ackID exceeds five bits");
  chk_rewind_index: assert property (txState_q == packet_buffer_pkg::TX_IDLE && rewindPend_q |=> sendId_q == ($past(nextPacketIndex) & $past(idMask))) else $error("rewind index not taken");
  chk_ack_free: assert property ((lastAckId & idMask) != (ackPrev_q & idMask) |=> tailId_q == $past(ackNext)) else $error("ack did not free slots");
  chk_stat_pattern: assert property (bufStat_q != 6'h3f && bufStat_q[4:0] != 5'h1f) else $error("status looks like flow control");
  chk_stat_cap: assert property (bufStat_q <= `PB_STAT_CAP) else $error("status above cap");
  chk_flow_mode: assert property ($changed(ctrl_q[`PB_CTRL_TXFC]) |=> txFlowControl_q == $past(ctrl_q[`PB_CTRL_TXFC])) else $error("flow mode output stale");
  chk_beat_hold: assert property (phytValid_q && !phytReady |=> phytValid_q && $stable(phyt_q)) else $error("outgoing beat changed early");

  cov_rewind_abort: cover property (phytValid_q && phyt_q.user[`PB_USER_DISC]);
  cov_rx_drop: cover property (rxDrop);
  cov_multi_free: cover property (((ackNext - tailId_q) & idMask) > 6'h01 && (lastAckId & idMask) != (ackPrev_q & idMask));
  cov_req_blocked: cover property (!masterEnable && sendId_q != wrId_q && !txStartResp ##1 masterEnable);
endmodule // packet_buffer_phy_link_side
`default_nettype wire

// file: tb/phy_link_model.sv
// Physical layer stand-in for the buffer's link side
`timescale 1ns/1ps
`default_nettype none
module phy_link_model #(
  parameter logic [5:0] PARTNER_STAT = 6'h15
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic slowReady,
  input wire logic holdAck,
  input wire logic phytValid,
  output var logic phytReady,
  input wire packet_buffer_pkg::beat_type phytBeat,
  output var logic phyrValid,
  input wire logic phyrReady,
  output var packet_buffer_pkg::beat_type phyrBeat,
  output var logic rewindRequest,
  output var logic [5:0] nextPacketIndex,
  output var logic [5:0] lastAckId,
  output var logic [5:0] partnerBufStat
);
  initial begin
    phytReady = 1'b0;
    phyrValid = 1'b0;
    phyrBeat = '0;
    rewindRequest = 1'b0;
    nextPacketIndex = 6'h00;
    lastAckId = 6'h3f;
    partnerBufStat = PARTNER_STAT;
  end
  // Random stalls force the buffer to hold some beats
  always @(posedge clk_sys) begin
    phytReady <= slowReady ? 1'($urandom) : 1'b1;
    if (sys_rst) begin
      nextPacketIndex <= 6'h00;
      lastAckId <= 6'h3f;
    end else begin
      if (phytValid && phytReady && phytBeat.last) begin
        nextPacketIndex <= nextPacketIndex + 6'h01;
      end
      if (!holdAck) begin
        lastAckId <= nextPacketIndex - 6'h01;
      end
    end
  end
  task automatic send_rx(input packet_buffer_pkg::beat_type b);
    phyrValid <= 1'b1;
    phyrBeat <= b;
    do @(posedge clk_sys); while (!phyrReady);
    if (b.last) begin
      phyrValid <= 1'b0;
      phyrBeat <= packet_buffer_pkg::beat_type'(~b);
      @(posedge clk_sys);
    end
  endtask
  // Asks for the last sent packet again
  task automatic rewind();
    // Let the index step from the last sent packet settle first
    @(posedge clk_sys);
    nextPacketIndex <= nextPacketIndex - 6'h01;
    rewindRequest <= 1'b1;
    @(posedge clk_sys);
    rewindRequest <= 1'b0;
  endtask
endmodule // phy_link_model
`default_nettype wire

// file: tb/packet_buffer_phy_link_side_tb.sv
// Self-checking bench for the packet buffer link side
`timescale 1ns/1ps
`default_nettype none
`include "packet_buffer_cfg.svh"
module packet_buffer_phy_link_side_tb;
  typedef packet_buffer_pkg::beat_type bt_type;
  logic clk_sys, sys_rst, txInValid, txInReady, rxOutValid, rxOutReady, phytValid, phytReady;
  logic phyrValid, phyrReady, masterEnable, longSymbolMode, rewindRequest, txFlowControl;
  logic slowReady, holdAck, crfEn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [23:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [5:0] nextPacketIndex, lastAckId, partnerBufStat, bufStat;
  bt_type txInBeat, rxOutBeat, phytBeat, phyrBeat;
  bt_type txExp[$];
  bt_type rxExp[$];
  int nFail, compares, nPhyt, cycles, n;
  packet_buffer_phy_link_side #(.TX_SLOTS(8), .TX_BEATS(4), .RX_DEPTH(128), .RX_PKT_BEATS(4))
      packet_buffer_phy_link_side_inst (.clk_sys, .sys_rst, .txInValid, .txInReady, .txInBeat,
      .rxOutValid, .rxOutReady, .rxOutBeat, .phytValid, .phytReady, .phytBeat, .phyrValid,
      .phyrReady, .phyrBeat, .masterEnable, .longSymbolMode, .rewindRequest, .nextPacketIndex,
      .lastAckId, .partnerBufStat, .bufStat, .txFlowControl, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  phy_link_model #(.PARTNER_STAT(6'h15)) phy_link_model_inst (.clk_sys, .sys_rst, .slowReady,
      .holdAck, .phytValid, .phytReady, .phytBeat, .phyrValid, .phyrReady, .phyrBeat,
      .rewindRequest, .nextPacketIndex, .lastAckId, .partnerBufStat);
  task automatic check(input string name, input logic [80:0] e, input logic [80:0] g);
    compares++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Result watcher: oldest note is compared to each transferred beat
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      nFail++;
      printVerdict();
    end
    if (!sys_rst && phytValid && phytReady) begin
      nPhyt++;
      if (txExp.size() == 0) check("phyt extra", 0, phytBeat);
      else check("phyt beat", txExp.pop_front(), phytBeat);
    end
    if (!sys_rst && rxOutValid && rxOutReady) begin
      if (rxExp.size() == 0) check("rx extra", 0, rxOutBeat);
      else check("rx beat", rxExp.pop_front(), rxOutBeat);
    end
    if (!sys_rst && (bufStat[4:0] === 5'h1f || bufStat > `PB_STAT_CAP)) begin
      check("bufStat range", `PB_STAT_CAP, bufStat);
    end
  end
  // Bready and rready stay high, so a response is taken as soon as it shows
  task automatic axi_write(input logic [23:0] a, input logic [31:0] wd, input logic [1:0] er);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= wd;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check("bresp", er, s_axi_bresp);
  endtask
  task automatic axi_read(input logic [23:0] a, output logic [31:0] rd, output logic [1:0] rr);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic send_tx(input int k, input logic resp, input logic flag, input int copies);
    bt_type b;
    bt_type q[$];
    for (int i = 0; i < k; i++) begin
      b.data = {$urandom, $urandom};
      b.last = (i == k - 1);
      b.keep = b.last ? 8'($urandom | 1) : `PB_KEEP_ALL;
      b.user = (i == 0) ? {3'h0, resp, 2'h0, flag, 1'b0} : 8'h00;
      txInValid <= 1'b1;
      txInBeat <= b;
      do @(posedge clk_sys); while (!txInReady);
      b.user = (i == 0) ? {6'h00, flag & crfEn, 1'b0} : 8'h00;
      q.push_back(b);
    end
    txInValid <= 1'b0;
    txInBeat <= bt_type'(~b);
    repeat (copies) txExp = {txExp, q};
    @(posedge clk_sys);
  endtask
  task automatic send_rx(input int k, input logic flag, input logic disc);
    bt_type b;
    bt_type q[$];
    for (int i = 0; i < k; i++) begin
      b.data = {$urandom, $urandom};
      b.last = (i == k - 1);
      b.keep = b.last ? 8'($urandom | 1) : `PB_KEEP_ALL;
      b.user = {6'h00, flag && i == 0, disc && b.last};
      phy_link_model_inst.send_rx(b);
      b.user = {6'h00, b.user[1] & crfEn, 1'b0};
      q.push_back(b);
    end
    if (!disc) rxExp = {rxExp, q};
  endtask
  task automatic drain(input int k);
    int t;
    t = 0;
    while (txExp.size() + rxExp.size() > k && t < 3000) begin
      @(posedge clk_sys);
      t++;
    end
    check("pending notes", k, txExp.size() + rxExp.size());
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    sys_rst = 1'b1;
    {txInValid, masterEnable, longSymbolMode, rxOutReady, slowReady, holdAck, crfEn} = 7'h34;
    txInBeat = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    s_axi_wstrb = 4'hf;
    {nFail, compares, nPhyt, cycles} = '0;
    void'($urandom(68775));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check("bufStat idle", `PB_STAT_CAP, bufStat);
    @(posedge clk_sys);
    axi_read(`PB_CTRL_OFFSET, d, r);
    check("ctrl reset", {`PB_RESP_OKAY, 32'h0}, {r, d});
    axi_write(`PB_CTRL_OFFSET, 32'h3, `PB_RESP_OKAY);
    crfEn = 1'b1;
    repeat (2) @(posedge clk_sys);
    check("flow mode on", 1'b1, txFlowControl);
    axi_read(`PB_STATUS_OFFSET, d, r);
    check("partner stat", 6'h15, d[21:16]);
    check("mode bits", 2'h3, d[25:24]);
    axi_write(24'h00000c, 32'h1, `PB_RESP_SLVERR);
    axi_read(24'h00000c, d, r);
    check("unmapped read", {`PB_RESP_SLVERR, 32'h0}, {r, d});
    slowReady <= 1'b1;
    repeat (6) send_tx($urandom_range(4, 1), 1'b1, 1'($urandom), 1);
    send_tx(2, 1'b0, 1'b1, 1);
    drain(0);
    masterEnable <= 1'b0;
    send_tx(1, 1'b1, 1'b0, 1);
    drain(0);
    n = nPhyt;
    send_tx(2, 1'b0, 1'b1, 1);
    repeat (20) @(posedge clk_sys);
    check("request held", n, nPhyt);
    masterEnable <= 1'b1;
    drain(0);
    longSymbolMode <= 1'b0;
    holdAck <= 1'b1;
    repeat (8) send_tx(1, 1'b1, 1'b0, 1);
    drain(0);
    repeat (3) @(posedge clk_sys);
    check("slots full", 1'b0, txInReady);
    holdAck <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("slots freed", 1'b1, txInReady);
    holdAck <= 1'b1;
    send_tx(3, 1'b1, 1'b1, 2);
    drain(3);
    phy_link_model_inst.rewind();
    drain(0);
    holdAck <= 1'b0;
    axi_write(`PB_CTRL_OFFSET, 32'h0, `PB_RESP_OKAY);
    crfEn = 1'b0;
    send_tx(2, 1'b1, 1'b1, 1);
    drain(0);
    check("flow mode off", 1'b0, txFlowControl);
    axi_write(`PB_CTRL_OFFSET, 32'h1, `PB_RESP_OKAY);
    crfEn = 1'b1;
    rxOutReady <= 1'b0;
    repeat (3) send_rx(4, 1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    check("bufStat estimate", 6'h1d, bufStat);
    rxOutReady <= 1'b1;
    send_rx(3, 1'b0, 1'b1);
    send_rx(1, 1'b1, 1'b0);
    drain(0);
    axi_read(`PB_DROPS_OFFSET, d, r);
    check("drop count", 16'h0001, d[15:0]);
    printVerdict();
  end
endmodule // packet_buffer_phy_link_side_tb
`default_nettype wire
